/* File: hdl/dib_pkg.sv */
// Purpose: Shared constants and types for the DC injection brake sequencer.
// Assumes: 100 MHz ref_clk; registers reached over AHB-Lite, one word each.
////////////////////////////////////////////////////////////////////////////////
package dib_pkg;

    // Timing base: all programmed times are in milliseconds.
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_DELAY = 8'h08;
    localparam logic [7:0] ADDR_TIME = 8'h0c;
    localparam logic [7:0] ADDR_RATED = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_COUNT = 8'h18;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Field widths and positions.
    localparam int CTRL_W = 5;
    localparam int LEVEL_W = 10;
    localparam int MS_W = 16;
    localparam int RATED_W = 11;
    localparam int COUNT_W = 16;
    localparam int STAT_TERM_BIT = 4;

    // Reset values.
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 10'h064;
    localparam logic [MS_W-1:0] DELAY_RST = 16'h01f4;
    localparam logic [MS_W-1:0] TIME_RST = 16'h03e8;
    localparam logic [RATED_W-1:0] RATED_RST = 11'h00a;

    // Input function selection for the brake input pin.
    localparam logic [1:0] FUNC_NONE = 2'h0;
    localparam logic [1:0] FUNC_ENABLE = 2'h1;
    localparam logic [1:0] FUNC_DISABLE = 2'h2;

    // Current limits in percent of motor rated current.
    localparam logic [LEVEL_W-1:0] LIMIT_STD_PCT = 10'h0fa;
    localparam logic [LEVEL_W-1:0] LIMIT_HEAVY_PCT = 10'h190;

    // Decay hold curve corners: current in amps, hold in milliseconds.
    localparam logic [RATED_W-1:0] DECAY_I0 = 11'h00a;
    localparam logic [RATED_W-1:0] DECAY_I1 = 11'h064;
    localparam logic [RATED_W-1:0] DECAY_I2 = 11'h1f4;
    localparam logic [RATED_W-1:0] DECAY_I3 = 11'h3e8;
    localparam logic [MS_W-1:0] DECAY_T0 = 16'h0190;
    localparam logic [MS_W-1:0] DECAY_T1 = 16'h0320;
    localparam logic [MS_W-1:0] DECAY_T2 = 16'h08fc;
    localparam logic [MS_W-1:0] DECAY_T3 = 16'h10cc;
    // Segment slopes as multiplier and right shift (ms per amp).
    localparam logic [11:0] SLOPE1_MUL = 12'h472;
    localparam int SLOPE1_SHR = 8;
    localparam logic [11:0] SLOPE2_MUL = 12'h00f;
    localparam int SLOPE2_SHR = 2;
    localparam logic [11:0] SLOPE3_MUL = 12'h004;
    localparam int SLOPE3_SHR = 0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_INJECT = 2'b10,
        ST_DECAY = 2'b11
    } dib_state_t;

    typedef struct packed {
        logic [1:0] inFunc;
        logic hall;
        logic heavy;
        logic brakeSel;
    } dib_ctrl_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
    } dib_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } dib_ahb_rsp_t;

    typedef struct packed {
        logic relay;
        logic dcOn;
        logic [LEVEL_W-1:0] dcLevelPct;
        logic olRunSel;
        logic olHeavy;
        logic olHall;
        logic extraStart;
    } dib_drive_t;

endpackage

/* File: hdl/dib_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous pin inputs.
// Assumes: The first flop feeds only the second.
// Notes: Freezes with the clock enable like all other state.
`timescale 1ns/1ps
`default_nettype none
module dib_sync #(
    parameter int W = 1
) (
    // Clock and control
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } dib_sync_st_t;

    dib_sync_st_t s;
    dib_sync_st_t next_s;

    always_comb
    begin
        next_s.meta = asyncIn;
        next_s.stable = s.meta;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            s <= '0;
        else if (clkEn)
            s <= next_s;
    end

    assign syncOut = s.stable;
endmodule
`default_nettype wire

/* File: hdl/dib_ms_timer.sv */
// Purpose: Loadable millisecond countdown timer.
// Assumes: load is a one-cycle request; TICK_CYCLES clocks per millisecond.
// Notes: done rises loadMs*TICK_CYCLES cycles after the load edge and holds.
`timescale 1ns/1ps
`default_nettype none
module dib_ms_timer #(
    parameter int W = 16,
    parameter int TICK_CYCLES = 100000
) (
    // Clock and control
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Request
    input wire logic load,
    input wire logic [W-1:0] loadMs,
    // Result
    output logic done
);
    localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    if (TICK_CYCLES < 1 || W < 1)
    begin : g_check
        $error("dib_ms_timer: TICK_CYCLES and W must be positive");
    end

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [W-1:0] ms;
        logic done;
    } dib_tmr_st_t;

    dib_tmr_st_t s;
    dib_tmr_st_t next_s;

    always_comb
    begin
        next_s = s;
        if (load)
        begin
            next_s.pre = '0;
            next_s.ms = loadMs;
            next_s.done = (loadMs == '0);
        end
        else if (!s.done)
        begin
            if (s.pre == PRE_LAST)
            begin
                next_s.pre = '0;
                next_s.ms = s.ms - W'(1);
                next_s.done = (s.ms == W'(1));
            end
            else
                next_s.pre = s.pre + PW'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            s <= '{pre: '0, ms: '0, done: 1'b1};
        else if (clkEn)
            s <= next_s;
    end

    assign done = s.done;
endmodule
`default_nettype wire

/* File: hdl/dib_brake_sequencer.sv */
// Purpose: DC injection brake sequencer with AHB-Lite register access.
// Assumes: stopCmd is a one-cycle pulse from logic on ref_clk; brakeInPin is a pin.
// Notes: One timer serves delay, brake time and decay hold in turn.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dib_brake_sequencer #(
    parameter int TICK_CYCLES = dib_pkg::MS_CYCLES
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // AHB-Lite slave
    input wire dib_pkg::dib_ahb_req_t ahbReq,
    input wire logic hready,
    output dib_pkg::dib_ahb_rsp_t ahbRsp,
    // Starter control
    input wire logic stopCmd,
    input wire logic brakeInPin,
    // Brake and overload drive
    output dib_pkg::dib_drive_t drive
);
    if (TICK_CYCLES < 1)
    begin : g_check
        $error("dib_brake_sequencer: TICK_CYCLES must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State record.

    typedef struct packed {
        dib_pkg::dib_state_t state;
        dib_pkg::dib_ctrl_t ctrl;
        logic [dib_pkg::LEVEL_W-1:0] level;
        logic [dib_pkg::MS_W-1:0] delayMs;
        logic [dib_pkg::MS_W-1:0] timeMs;
        logic [dib_pkg::RATED_W-1:0] rated;
        logic terminated;
        logic [dib_pkg::COUNT_W-1:0] brakeCount;
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] hrdata;
        logic loadPrev;
        dib_pkg::dib_drive_t drv;
    } dib_seq_st_t;

    dib_seq_st_t s;
    dib_seq_st_t next_s;

    logic brakeIn;
    logic timerDone;
    logic timerLoad;
    logic timerLoadPrev;
    logic [dib_pkg::MS_W-1:0] timerMs;
    logic permit;
    logic addrPhase;
    logic [dib_pkg::LEVEL_W-1:0] limitPct;
    logic [dib_pkg::LEVEL_W-1:0] effLevel;
    logic [dib_pkg::MS_W-1:0] decayMs;
    logic [23:0] segProd;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and shared timer.

    dib_sync #(
        .W(1)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .asyncIn(brakeInPin),
        .syncOut(brakeIn)
    );

    dib_ms_timer #(
        .W(dib_pkg::MS_W),
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .load(timerLoad),
        .loadMs(timerMs),
        .done(timerDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Derived values.

    // The input function decides whether braking may go on right now.
    always_comb
    begin
        unique case (s.ctrl.inFunc)
            dib_pkg::FUNC_ENABLE: permit = brakeIn;
            dib_pkg::FUNC_DISABLE: permit = !brakeIn;
            default: permit = 1'b1;
        endcase
    end

    // The programmed level is clamped to what the duty type allows.
    always_comb
    begin
        limitPct = s.ctrl.heavy ? dib_pkg::LIMIT_HEAVY_PCT : dib_pkg::LIMIT_STD_PCT;
        effLevel = (s.level > limitPct) ? limitPct : s.level;
    end

    // Piecewise-linear decay hold through the published corners. A shift
    // approximation of the first slope keeps the design free of dividers.
    always_comb
    begin
        segProd = '0;
        if (s.rated <= dib_pkg::DECAY_I0)
            decayMs = dib_pkg::DECAY_T0;
        else if (s.rated <= dib_pkg::DECAY_I1)
        begin
            segProd = 24'(s.rated - dib_pkg::DECAY_I0) * 24'(dib_pkg::SLOPE1_MUL);
            decayMs = dib_pkg::DECAY_T0 + dib_pkg::MS_W'(segProd >> dib_pkg::SLOPE1_SHR);
        end
        else if (s.rated <= dib_pkg::DECAY_I2)
        begin
            segProd = 24'(s.rated - dib_pkg::DECAY_I1) * 24'(dib_pkg::SLOPE2_MUL);
            decayMs = dib_pkg::DECAY_T1 + dib_pkg::MS_W'(segProd >> dib_pkg::SLOPE2_SHR);
        end
        else
        begin
            segProd = 24'(s.rated - dib_pkg::DECAY_I2) * 24'(dib_pkg::SLOPE3_MUL);
            decayMs = dib_pkg::DECAY_T2 + dib_pkg::MS_W'(segProd >> dib_pkg::SLOPE3_SHR);
        end
    end

    assign addrPhase = ahbReq.hsel && ahbReq.htrans[1] && hready;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb
    begin
        next_s = s;
        next_s.drv.extraStart = 1'b0;
        timerLoad = 1'b0;
        timerMs = '0;

        // Write data phase of a transfer accepted in the previous cycle.
        if (s.wrPend)
        begin
            unique case (s.wrAddr)
                dib_pkg::ADDR_CTRL:
                    next_s.ctrl = dib_pkg::dib_ctrl_t'(ahbReq.hwdata[dib_pkg::CTRL_W-1:0]);
                dib_pkg::ADDR_LEVEL:
                    next_s.level = ahbReq.hwdata[dib_pkg::LEVEL_W-1:0];
                dib_pkg::ADDR_DELAY:
                    next_s.delayMs = ahbReq.hwdata[dib_pkg::MS_W-1:0];
                dib_pkg::ADDR_TIME:
                    next_s.timeMs = ahbReq.hwdata[dib_pkg::MS_W-1:0];
                dib_pkg::ADDR_RATED:
                    next_s.rated = ahbReq.hwdata[dib_pkg::RATED_W-1:0];
                dib_pkg::ADDR_STATUS:
                    if (ahbReq.hwdata[dib_pkg::STAT_TERM_BIT])
                        next_s.terminated = 1'b0;
                default:
                    next_s.terminated = next_s.terminated;
            endcase
        end

        // Address phase: latch writes, prepare read data for the data phase.
        next_s.wrPend = addrPhase && ahbReq.hwrite && (ahbReq.hsize == dib_pkg::HSIZE_WORD);
        next_s.wrAddr = ahbReq.haddr[7:0];
        if (addrPhase && !ahbReq.hwrite)
        begin
            unique case (ahbReq.haddr[7:0])
                dib_pkg::ADDR_CTRL:
                    next_s.hrdata = 32'(s.ctrl);
                dib_pkg::ADDR_LEVEL:
                    next_s.hrdata = 32'(s.level);
                dib_pkg::ADDR_DELAY:
                    next_s.hrdata = 32'(s.delayMs);
                dib_pkg::ADDR_TIME:
                    next_s.hrdata = 32'(s.timeMs);
                dib_pkg::ADDR_RATED:
                    next_s.hrdata = 32'(s.rated);
                dib_pkg::ADDR_STATUS:
                    next_s.hrdata = 32'({permit, s.terminated, s.drv.dcOn, s.drv.relay,
                        s.state});
                dib_pkg::ADDR_COUNT:
                    next_s.hrdata = 32'(s.brakeCount);
                default:
                    next_s.hrdata = '0;
            endcase
        end

        // Brake sequence. A stop while already braking is ignored.
        unique case (s.state)
            dib_pkg::ST_IDLE:
            begin
                if (stopCmd && s.ctrl.brakeSel && permit)
                begin
                    next_s.state = dib_pkg::ST_DELAY;
                    timerLoad = 1'b1;
                    timerMs = s.delayMs;
                end
            end
            dib_pkg::ST_DELAY:
            begin
                if (!permit)
                begin
                    next_s.state = dib_pkg::ST_IDLE;
                    next_s.terminated = 1'b1;
                end
                else if (timerDone && !timerLoadPrev)
                begin
                    next_s.state = dib_pkg::ST_INJECT;
                    next_s.brakeCount = s.brakeCount + dib_pkg::COUNT_W'(1);
                    next_s.drv.extraStart = 1'b1;
                    timerLoad = 1'b1;
                    timerMs = s.timeMs;
                end
            end
            dib_pkg::ST_INJECT:
            begin
                if (!permit)
                begin
                    next_s.state = dib_pkg::ST_IDLE;
                    next_s.terminated = 1'b1;
                end
                else if (timerDone && !timerLoadPrev)
                begin
                    next_s.state = dib_pkg::ST_DECAY;
                    timerLoad = 1'b1;
                    timerMs = decayMs;
                end
            end
            dib_pkg::ST_DECAY:
            begin
                if (timerDone && !timerLoadPrev)
                    next_s.state = dib_pkg::ST_IDLE;
            end
        endcase

        // Outputs follow the next state so they change with it.
        next_s.drv.relay = (next_s.state != dib_pkg::ST_IDLE);
        next_s.drv.dcOn = (next_s.state == dib_pkg::ST_INJECT);
        next_s.drv.dcLevelPct = next_s.drv.dcOn ? effLevel : '0;
        next_s.drv.olRunSel = next_s.drv.relay;
        next_s.drv.olHeavy = next_s.drv.relay && s.ctrl.heavy;
        next_s.drv.olHall = next_s.drv.relay && s.ctrl.hall;
        next_s.loadPrev = timerLoad;
    end

    ////////////////////////////////////////////////////////////////////////////
    // A done seen in the cycle right after a load already reflects that load,
    // but it is not taken then, so a phase loaded with zero still lasts two cycles.

    assign timerLoadPrev = s.loadPrev;

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.state <= dib_pkg::ST_IDLE;
            s.ctrl <= '{inFunc: dib_pkg::FUNC_NONE, hall: 1'b0, heavy: 1'b0, brakeSel: 1'b0};
            s.level <= dib_pkg::LEVEL_RST;
            s.delayMs <= dib_pkg::DELAY_RST;
            s.timeMs <= dib_pkg::TIME_RST;
            s.rated <= dib_pkg::RATED_RST;
        end
        else if (clkEn)
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs. The bus stalls while the block is frozen.

    always_comb
    begin
        ahbRsp.hrdata = s.hrdata;
        ahbRsp.hreadyout = clkEn;
        ahbRsp.hresp = 1'b0;
    end

    assign drive = s.drv;
endmodule
`default_nettype wire

/* File: sim/dib_brake_assertions.sv */
// Purpose: Port-level checker for the brake sequencer.
// Assumes: One clock domain; clkEn stays high in the bench.
// Notes: Hold length is judged against the shortest decay figure.
`timescale 1ns/1ps
`default_nettype none
module dib_brake_checker #(
    parameter int TICK_CYCLES = 10
) (
    // Clock and control
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Bus
    input wire dib_pkg::dib_ahb_req_t ahbReq,
    input wire logic hready,
    input wire dib_pkg::dib_ahb_rsp_t ahbRsp,
    // Starter side
    input wire logic stopCmd,
    input wire logic brakeInPin,
    input wire dib_pkg::dib_drive_t drive
);
    localparam int MIN_HOLD = 400 * TICK_CYCLES - 4;
    logic inDecay;
    int holdCnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    // A decay hold starts where DC falls with the relay still energized.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            inDecay <= 1'b0;
            holdCnt <= 0;
        end
        else if ($fell(drive.dcOn) && drive.relay)
        begin
            inDecay <= 1'b1;
            holdCnt <= 1;
        end
        else if (!drive.relay)
        begin
            inDecay <= 1'b0;
            holdCnt <= 0;
        end
        else if (inDecay)
            holdCnt <= holdCnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    relay_on_stop_a: assert property ($rose(drive.relay) |-> $past(stopCmd))
        else $error("relay rose without a stop");
    dc_inside_relay_a: assert property (drive.dcOn |-> drive.relay && $past(drive.relay))
        else $error("dc current outside relay window");
    extra_start_a: assert property (drive.extraStart |-> $rose(drive.dcOn) ##1 !drive.extraStart)
        else $error("extra start pulse misplaced");
    level_idle_a: assert property (!drive.dcOn |-> drive.dcLevelPct == 10'h000)
        else $error("level set while dc off");
    level_limit_a: assert property (drive.dcOn |->
        drive.dcLevelPct <= (drive.olHeavy ? 10'h190 : 10'h0fa))
        else $error("level above duty limit");
    ol_running_a: assert property (drive.relay |-> drive.olRunSel)
        else $error("running overload not selected");
    decay_hold_a: assert property ($fell(drive.dcOn) && drive.relay |-> drive.relay[*8])
        else $error("relay dropped right after dc");
    decay_length_a: assert property (inDecay && !drive.relay |-> holdCnt >= MIN_HOLD)
        else $error("decay hold too short");
    relay_release_a: assert property ($fell(drive.relay) |-> !drive.dcOn)
        else $error("relay released under dc");
    bus_ready_a: assert property (ahbRsp.hreadyout == clkEn && !ahbRsp.hresp)
        else $error("bad ready or response");
    ////////////////////////////////////////////////////////////////////////////
    inject_c: cover property (drive.extraStart);
    decay_end_c: cover property (inDecay && !drive.relay);
    abort_c: cover property ($fell(drive.dcOn) && !drive.relay);
endmodule
bind dib_brake_sequencer dib_brake_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .ahbReq(ahbReq),
    .hready(hready),
    .ahbRsp(ahbRsp),
    .stopCmd(stopCmd),
    .brakeInPin(brakeInPin),
    .drive(drive)
);
`default_nettype wire

/* File: sim/dib_brake_partner.sv */
// Purpose: Braking contactor and operator input at the far side.
// Assumes: The relay output is the one assigned to braking.
// Notes: Closing time is arbitrary; dc into an open path is flagged.
`timescale 1ns/1ps
`default_nettype none
module dib_brake_partner #(
    parameter int CLOSE_CYCLES = 5
) (
    // Clock
    input wire logic ref_clk,
    input wire logic sys_rst,
    // From the sequencer
    input wire logic relay,
    input wire logic dcOn,
    // Operator
    input wire logic opLevel,
    output logic brakeInPin,
    // Observation
    output logic closed,
    output logic arcFault
);
    int closeCnt;
    // The operator level drives the brake input pin directly.
    assign brakeInPin = opLevel;
    assign closed = relay && (closeCnt >= CLOSE_CYCLES);
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !relay)
            closeCnt <= 0;
        else if (closeCnt < CLOSE_CYCLES)
            closeCnt <= closeCnt + 1;
        if (sys_rst)
            arcFault <= 1'b0;
        else if (dcOn && !closed)
            arcFault <= 1'b1;
    end
endmodule
`default_nettype wire

/* File: sim/dib_brake_sequencer_test.sv */
// Purpose: Self-checking bench for the brake sequencer.
// Assumes: TICK_CYCLES of 10, so one ms is ten clocks.
// Notes: Timing is accepted within four cycles of the figure.
`timescale 1ns/1ps
`default_nettype none
module dib_brake_sequencer_test;
    localparam int TICK = 10;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic stopCmd = 1'b0;
    logic opLevel = 1'b0;
    logic brakeInPin;
    logic closed;
    logic arcFault;
    dib_pkg::dib_ahb_req_t req = '0;
    dib_pkg::dib_ahb_rsp_t rsp;
    dib_pkg::dib_drive_t drive;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] rd;
    dib_brake_sequencer #(.TICK_CYCLES(TICK)) u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn), .ahbReq(req),
        .hready(rsp.hreadyout), .ahbRsp(rsp), .stopCmd(stopCmd),
        .brakeInPin(brakeInPin), .drive(drive));
    dib_brake_partner u_far (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .relay(drive.relay), .dcOn(drive.dcOn),
        .opLevel(opLevel), .brakeInPin(brakeInPin), .closed(closed), .arcFault(arcFault));
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic near(input int n, input int e);
        chk(32'(n), (n >= e - 4 && n <= e + 4) ? 32'(n) : 32'(e));
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    // Waiting on hready is bounded by the watchdog alone.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, {24'h000000, a}, 2'h2, w, dib_pkg::HSIZE_WORD, req.hwdata};
        @(posedge ref_clk);
        while (rsp.hreadyout !== 1'b1) @(posedge ref_clk);
        req <= '{1'b0, req.haddr, 2'h0, req.hwrite, req.hsize, d};
        @(posedge ref_clk);
        while (rsp.hreadyout !== 1'b1) @(posedge ref_clk);
        rd = rsp.hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h00000000);
        chk(rd, e);
    endtask
    task automatic stop_pulse();
        @(posedge ref_clk);
        stopCmd <= 1'b1;
        @(posedge ref_clk);
        stopCmd <= 1'b0;
        #1;
    endtask
    task automatic waitv(input logic dc, input logic v, output int n);
        n = 0;
        while (((dc ? drive.dcOn : drive.relay) !== v) && n < 60000)
        begin
            tick();
            n++;
        end
    endtask
    task automatic level(input logic v);
        @(posedge ref_clk);
        opLevel <= v;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk(dib_pkg::ADDR_CTRL, 32'h00000000);
        rdchk(dib_pkg::ADDR_LEVEL, 32'h00000064);
        rdchk(dib_pkg::ADDR_DELAY, 32'h000001f4);
        rdchk(dib_pkg::ADDR_TIME, 32'h000003e8);
        rdchk(dib_pkg::ADDR_RATED, 32'h0000000a);
        ahb(1'b1, 8'h1c, 32'h0000ffff);
        rdchk(8'h1c, 32'h00000000);
        rdchk(dib_pkg::ADDR_COUNT, 32'h00000000);
    endtask
    // Delay 3 ms and brake time 2 ms keep the sequence short.
    task automatic run_full(input logic [31:0] ctrl, input logic [31:0] lvl,
        input logic [31:0] rated, input logic [9:0] expLvl, input int decayMs,
        input logic [31:0] cnt);
        int n;
        ahb(1'b1, dib_pkg::ADDR_CTRL, ctrl);
        ahb(1'b1, dib_pkg::ADDR_LEVEL, lvl);
        ahb(1'b1, dib_pkg::ADDR_DELAY, 32'h00000003);
        ahb(1'b1, dib_pkg::ADDR_TIME, 32'h00000002);
        ahb(1'b1, dib_pkg::ADDR_RATED, rated);
        stop_pulse();
        chk(drive.relay, 1'b1);
        waitv(1'b1, 1'b1, n);
        near(n, 3 * TICK + 1);
        chk(drive.extraStart, 1'b1);
        chk(drive.dcLevelPct, expLvl);
        chk({drive.olRunSel, drive.olHeavy, drive.olHall}, {1'b1, ctrl[1], ctrl[2]});
        waitv(1'b1, 1'b0, n);
        near(n, 2 * TICK + 2);
        chk(drive.relay, 1'b1);
        waitv(1'b0, 1'b0, n);
        near(n, decayMs * TICK + 2);
        rdchk(dib_pkg::ADDR_STATUS, 32'h00000020);
        rdchk(dib_pkg::ADDR_COUNT, cnt);
    endtask
    task automatic t_standard();
        run_full(32'h00000001, 32'h0000012c, 32'h0000000a, 10'h0fa, 400, 32'h1);
    endtask
    task automatic t_heavy_hall();
        run_full(32'h00000007, 32'h000001f4, 32'h00000064, 10'h190, 800, 32'h2);
    endtask
    task automatic t_enable_abort();
        int n;
        ahb(1'b1, dib_pkg::ADDR_CTRL, 32'h00000009);
        stop_pulse();
        repeat (5) tick();
        chk(drive.relay, 1'b0);
        level(1'b1);
        repeat (4) tick();
        stop_pulse();
        waitv(1'b1, 1'b1, n);
        level(1'b0);
        waitv(1'b0, 1'b0, n);
        near(n, 3);
        chk(drive.dcOn, 1'b0);
        rdchk(dib_pkg::ADDR_STATUS, 32'h00000010);
        level(1'b1);
        repeat (50) tick();
        chk(drive.relay, 1'b0);
        ahb(1'b1, dib_pkg::ADDR_STATUS, 32'h00000010);
        rdchk(dib_pkg::ADDR_STATUS, 32'h00000020);
        rdchk(dib_pkg::ADDR_COUNT, 32'h00000003);
    endtask
    task automatic t_disable_abort();
        int n;
        ahb(1'b1, dib_pkg::ADDR_CTRL, 32'h00000011);
        stop_pulse();
        repeat (5) tick();
        chk(drive.relay, 1'b0);
        level(1'b0);
        repeat (4) tick();
        stop_pulse();
        chk(drive.relay, 1'b1);
        repeat (5) tick();
        level(1'b1);
        waitv(1'b0, 1'b0, n);
        near(n, 3);
        rdchk(dib_pkg::ADDR_STATUS, 32'h00000010);
        rdchk(dib_pkg::ADDR_COUNT, 32'h00000003);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_standard();
        t_heavy_hall();
        t_enable_abort();
        t_disable_abort();
        chk(arcFault, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
